// [ihti_pkg.sv]
// Package for the interrupt hold and test input block: register map, fields, carriers
package ihti_pkg;

  // Register selects for the instruction-side register port
  localparam logic [1:0] IHTI_SEL_REQUEST = 2'h0;
  localparam logic [1:0] IHTI_SEL_MASK    = 2'h1;
  localparam logic [1:0] IHTI_SEL_KEYRET  = 2'h2;

  // Reset values
  localparam logic [7:0] IHTI_REQUEST_RST = 8'h00;
  localparam logic [7:0] IHTI_MASK_RST    = 8'hff;
  localparam logic [7:0] IHTI_KEYRET_RST  = 8'h02;

  // Field positions in the request and mask registers
  localparam int IHTI_WATCH_BIT = 0;
  localparam int IHTI_KEY_BIT   = 1;
  // Field position of the key return standby enable in the key return register
  localparam int IHTI_KEYRET_EN_BIT = 0;

  // Storage masks: bits 3 to 6 of request and mask registers are not stored
  localparam logic [7:0] IHTI_FLAG_STORE = 8'h87;
  localparam logic [7:0] IHTI_FLAG_FIXED_REQ = 8'h00;
  localparam logic [7:0] IHTI_FLAG_FIXED_MSK = 8'h78;

  // Number of maskable sources arbitrated at an instruction boundary
  localparam int IHTI_NSRC = 8;
  localparam int IHTI_IDXW = 3;

  // Class of the instruction that just completed
  typedef struct packed {
    logic hold;   // Pending-class instruction (psw access, ei, di, returns, flag regs)
    logic software_break_instruction;    // Software break
  } ihti_instr_t;

  // One register manipulation from an instruction
  typedef struct packed {
    logic       wr;
    logic       bit_op;
    logic [1:0] sel;
    logic [2:0] bit_idx;
    logic [7:0] data;
  } ihti_reg_wr_t;

  // Acknowledge decision handed to the sequencer
  typedef struct packed {
    logic                 maskable;
    logic                 nmi;
    logic [IHTI_IDXW-1:0] source;
  } ihti_ack_t;

endpackage

// [ihti_top.sv]
// Interrupt acknowledge gating, pending-instruction hold and test input flags
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Lower priority request during enabled servicing waits until after one main instruction.
// - With acknowledge never re-enabled, any maskable request waits until after return.
// - Requests during psw, ei, di, return instructions wait for next instruction.
// - Manipulating flag, mask, priority or edge mode registers also defers acknowledge.
// - Break never defers; maskable requests then refused, non-maskable still taken.
// - Priority selection never changes how request flags are set or held.
// - Watch overflow or key falling edge sets its test flag and, when unmasked (key also needs key return enable bit 0), releases standby.
// - Test input events never produce a vectored acknowledge.
// - Watch overflow sets watch flag; standby release only when watch mask clear.
// - Falling edge on any key line sets key flag; release when key mask clear and key return enable bit 0 set.
// - Key flag stays set until software writes zero; hardware never clears it.
// - Request flag register resets to all zeros.
// - Key return register gates key standby release, resets to 02h.
// - All three registers accept single-bit and whole-byte writes.
// - With acknowledge enabled, equal or higher priority nests, lower refused.
module ihti_top
  import ihti_pkg::*;
(
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  // Sequencer status
  input  wire logic                       instr_done_in,
  input  wire ihti_pkg::ihti_instr_t      instr_class_in,
  input  wire logic                       maskable_ack_enable_in,
  input  wire logic                       in_service_priority_in,
  // Maskable and non-maskable requests
  input  wire logic [ihti_pkg::IHTI_NSRC-1:0] req_pending_in,
  input  wire logic [ihti_pkg::IHTI_NSRC-1:0] priority_select_flag_in,
  input  wire logic                       nmi_req_in,
  input  wire logic                       intr_reg_touch_in,
  // Test input sources
  input  wire logic                       watch_overflow_source_in,
  input  wire logic [7:0]                 key_port_in,
  // Register manipulation port
  input  wire ihti_pkg::ihti_reg_wr_t     reg_wr_in,
  input  wire logic [1:0]                 rd_sel_in,
  // Outputs
  output logic [7:0]                      rd_data_out,
  output ihti_pkg::ihti_ack_t             ack_out,
  output logic                            standby_release_out,
  output logic                            watch_test_flag_out,
  output logic                            key_test_flag_out
);
  import ihti_pkg::*;

  logic [7:0]           request_flag_group_one_low;
  logic [7:0]           mask_flag_group_one_low;
  logic [7:0]           key_return_control;
  logic [7:0]           key_prev;
  logic                 touched;
  logic [7:0]           next_request;
  logic [7:0]           next_mask;
  logic [7:0]           next_keyret;
  logic [7:0]           rd_mux;
  logic                 key_edge;
  logic                 watch_rel;
  logic                 key_rel;
  logic                 defer;
  logic                 maskable_ok;
  logic                 found;
  logic [IHTI_IDXW-1:0] pick;
  logic [IHTI_NSRC-1:0] nestable;
  ihti_ack_t            next_ack;

  // Write value of one register; bit operations touch only the addressed bit
  function automatic logic [7:0] wr_value(input logic [7:0] cur, input ihti_reg_wr_t w);
    logic [7:0] v;
    v = cur;
    if (w.bit_op) begin
      v[w.bit_idx] = w.data[0];
    end else begin
      v = w.data;
    end
    return v;
  endfunction

  // Write decode
  wire wr_req = reg_wr_in.wr && (reg_wr_in.sel == IHTI_SEL_REQUEST);
  wire wr_msk = reg_wr_in.wr && (reg_wr_in.sel == IHTI_SEL_MASK);
  wire wr_krc = reg_wr_in.wr && (reg_wr_in.sel == IHTI_SEL_KEYRET);
  wire [7:0] req_wr_val = wr_value(request_flag_group_one_low, reg_wr_in);
  wire [7:0] msk_wr_val = wr_value(mask_flag_group_one_low, reg_wr_in);

  // Falling edge on any key line; inputs are synchronous to the core clock
  // key edge detect
  assign key_edge = |(key_prev & ~key_port_in);

  // Flag update: event set is ORed after the write so it wins over a clear
  // bit and byte writes
  always_comb begin
    next_request = wr_req ? ((req_wr_val & IHTI_FLAG_STORE) | IHTI_FLAG_FIXED_REQ)
                          : request_flag_group_one_low;
    if (watch_overflow_source_in) begin
      next_request[IHTI_WATCH_BIT] = 1'b1;
    end
    if (key_edge) begin
      next_request[IHTI_KEY_BIT] = 1'b1;
    end
  end

  // Mask and key return next values; unstored mask bits read as ones
  assign next_mask   = wr_msk ? ((msk_wr_val & IHTI_FLAG_STORE) | IHTI_FLAG_FIXED_MSK)
                              : mask_flag_group_one_low;
  assign next_keyret = wr_krc ? wr_value(key_return_control, reg_wr_in) : key_return_control;

  // Standby release terms; never a vectored acknowledge
  // standby release
  assign watch_rel = watch_overflow_source_in && !mask_flag_group_one_low[IHTI_WATCH_BIT];
  assign key_rel   = key_edge && !mask_flag_group_one_low[IHTI_KEY_BIT] &&
                     key_return_control[IHTI_KEYRET_EN_BIT];

  // Read mux; unused selects read zero
  assign rd_mux = (rd_sel_in == IHTI_SEL_REQUEST) ? request_flag_group_one_low :
                  (rd_sel_in == IHTI_SEL_MASK)    ? mask_flag_group_one_low :
                  (rd_sel_in == IHTI_SEL_KEYRET)  ? key_return_control : 8'h00;

  // Deferral: a pending-class instruction, or one that touched flag registers,
  // pushes acknowledge past the next instruction boundary
  // pending instructions
  assign defer = instr_class_in.hold || touched || intr_reg_touch_in || reg_wr_in.wr;

  // Nesting: enabled and (high priority request or nothing high in service)
  // equal or higher nests
  assign nestable = req_pending_in &
                    ~(priority_select_flag_in & {IHTI_NSRC{~in_service_priority_in}});
  assign maskable_ok = maskable_ack_enable_in && !instr_class_in.software_break_instruction;

  // Pick high programmable priority first, then lowest index as default priority
  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int i = IHTI_NSRC - 1; i >= 0; i--) begin
      if (nestable[i] && !priority_select_flag_in[i]) begin
        found = 1'b1;
        pick  = IHTI_IDXW'(i);
      end
    end
    if (!found) begin
      for (int i = IHTI_NSRC - 1; i >= 0; i--) begin
        if (nestable[i]) begin
          found = 1'b1;
          pick  = IHTI_IDXW'(i);
        end
      end
    end
  end

  // Acknowledge decision at an instruction boundary
  // no test vectoring
  always_comb begin
    next_ack = '0;
    if (instr_done_in && !defer) begin
      if (nmi_req_in) begin
        next_ack.nmi = 1'b1;
      end else if (maskable_ok && found) begin
        next_ack.maskable = 1'b1;
        next_ack.source   = pick;
      end
    end
  end

  // Register flops
  // request reset zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      request_flag_group_one_low <= IHTI_REQUEST_RST;
      mask_flag_group_one_low    <= IHTI_MASK_RST;
      key_return_control         <= IHTI_KEYRET_RST;
    end else begin
      request_flag_group_one_low <= next_request;
      mask_flag_group_one_low    <= next_mask;
      key_return_control         <= next_keyret;
    end
  end

  // Key history starts high so a port already low at release is seen as a falling edge
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_prev <= 8'hff;
    end else begin
      key_prev <= key_port_in;
    end
  end

  // Register touch within the current instruction, cleared at its boundary
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      touched <= 1'b0;
    end else if (instr_done_in) begin
      touched <= 1'b0;
    end else if (reg_wr_in.wr || intr_reg_touch_in) begin
      touched <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out         <= 8'h00;
      ack_out             <= '0;
      standby_release_out <= 1'b0;
      watch_test_flag_out <= 1'b0;
      key_test_flag_out   <= 1'b0;
    end else begin
      rd_data_out         <= rd_mux;
      ack_out             <= next_ack;
      standby_release_out <= watch_rel || key_rel;
      watch_test_flag_out <= next_request[IHTI_WATCH_BIT];
      key_test_flag_out   <= next_request[IHTI_KEY_BIT];
    end
  end

endmodule
`default_nettype wire

// [ihti_chk.sv]
// Port checker for the interrupt hold and test input block
`timescale 1ns/100ps
`default_nettype none
module ihti_chk
  import ihti_pkg::*;
(
  // Clock and reset
  input wire logic                 ref_clk_in,
  input wire logic                 rst_n_in,
  // Inputs watched
  input wire logic                 instr_done_in,
  input wire ihti_pkg::ihti_instr_t instr_class_in,
  input wire logic                 maskable_ack_enable_in,
  input wire logic                 in_service_priority_in,
  input wire logic [7:0]           priority_select_flag_in,
  input wire logic                 nmi_req_in,
  input wire logic                 intr_reg_touch_in,
  input wire logic                 watch_overflow_source_in,
  input wire logic [7:0]           key_port_in,
  input wire ihti_pkg::ihti_reg_wr_t reg_wr_in,
  // Outputs watched
  input wire ihti_pkg::ihti_ack_t  ack_out,
  input wire logic                 standby_release_out,
  input wire logic                 watch_test_flag_out,
  input wire logic                 key_test_flag_out
);
  logic [7:0] kp;
  logic [7:0] pr;
  logic       dirty;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Dirty is kept conservative: a touch at a boundary may also count for the next one
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kp <= 8'hff;
      pr <= 8'h00;
      dirty <= 1'b0;
    end else begin
      kp <= key_port_in;
      pr <= priority_select_flag_in;
      dirty <= (dirty && !instr_done_in) || intr_reg_touch_in || reg_wr_in.wr;
    end
  end
  AST_WATCH_SET: assert property (watch_overflow_source_in |=> watch_test_flag_out)
    else $error("watch flag not set");
  AST_REL_CAUSE: assert property (standby_release_out |->
    $past(watch_overflow_source_in) || $past(|(kp & ~key_port_in)))
    else $error("standby release without event");
  AST_NO_VECTOR: assert property (ack_out != '0 |-> $past(instr_done_in))
    else $error("ack away from boundary");
  AST_HOLD: assert property (instr_done_in && instr_class_in.hold |=> ack_out == '0)
    else $error("ack after hold instruction");
  AST_TOUCH: assert property (instr_done_in && (intr_reg_touch_in || reg_wr_in.wr)
    |=> ack_out == '0) else $error("ack after register touch");
  AST_BRK: assert property (instr_done_in && instr_class_in.software_break_instruction |=> !ack_out.maskable)
    else $error("maskable ack after break");
  AST_PRIO: assert property (ack_out.maskable |-> $past(maskable_ack_enable_in) &&
    ($past(in_service_priority_in) || !pr[ack_out.source])) else $error("bad nesting");
  AST_NMI: assert property (instr_done_in && nmi_req_in && !instr_class_in.hold &&
    !dirty && !intr_reg_touch_in && !reg_wr_in.wr |=> ack_out.nmi) else $error("nmi lost");
  AST_KEY_HOLD: assert property (key_test_flag_out && !reg_wr_in.wr &&
    !$past(reg_wr_in.wr) |=> key_test_flag_out) else $error("key flag dropped");
endmodule
bind ihti_top ihti_chk chk (.ref_clk_in, .rst_n_in, .instr_done_in, .instr_class_in,
  .maskable_ack_enable_in, .in_service_priority_in, .priority_select_flag_in, .nmi_req_in,
  .intr_reg_touch_in, .watch_overflow_source_in, .key_port_in, .reg_wr_in, .ack_out,
  .standby_release_out, .watch_test_flag_out, .key_test_flag_out);
`default_nettype wire

// [ihti_src.sv]
// Event source model: watch timer overflow pulses and key port lines
`timescale 1ns/100ps
`default_nettype none
module ihti_src (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  // Commands from the bench
  input  wire logic       tick_in,
  input  wire logic [7:0] key_in,
  // Lines toward the block
  output logic            watch_out,
  output logic [7:0]      key_out
);
  // one pulse per overflow; key lines rest high like pulled-up inputs
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watch_out <= 1'b0;
      key_out <= 8'hff;
    end else begin
      watch_out <= tick_in;
      key_out <= key_in;
    end
  end
endmodule
`default_nettype wire

// [interrupt_hold_and_test_input_tb.sv]
// Self-checking bench for the interrupt hold and test input block
`timescale 1ns/100ps
`default_nettype none
module interrupt_hold_and_test_input_tb;
  import ihti_pkg::*;
  logic ref_clk_in, rst_n_in, instr_done_in, maskable_ack_enable_in, in_service_priority_in;
  logic nmi_req_in, intr_reg_touch_in, watch_overflow_source_in, tick;
  logic standby_release_out, watch_test_flag_out, key_test_flag_out;
  logic [7:0] req_pending_in, priority_select_flag_in, key_port_in, key_cmd, rd_data_out;
  logic [1:0] rd_sel_in;
  ihti_instr_t instr_class_in;
  ihti_reg_wr_t reg_wr_in;
  ihti_ack_t ack_out;
  logic [7:0] m [4];
  logic [7:0] kp;
  logic [31:0] seed, r;
  int error_cnt, total_checks, cycles;
  ihti_src src (.ref_clk_in, .rst_n_in, .tick_in(tick), .key_in(key_cmd),
    .watch_out(watch_overflow_source_in), .key_out(key_port_in));
  ihti_top dut (.ref_clk_in, .rst_n_in, .instr_done_in, .instr_class_in,
    .maskable_ack_enable_in, .in_service_priority_in, .req_pending_in,
    .priority_select_flag_in, .nmi_req_in, .intr_reg_touch_in, .watch_overflow_source_in,
    .key_port_in, .reg_wr_in, .rd_sel_in, .rd_data_out, .ack_out, .standby_release_out,
    .watch_test_flag_out, .key_test_flag_out);
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task results;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      results;
    end
  end
  task cyc;
    @(posedge ref_clk_in);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Model decision: lowest index among high priority first, then low priority
  function automatic logic [4:0] mack(input int h, input int b, input int t);
    int i;
    mack = 5'h00;
    if (h || t) return 5'h00;
    if (nmi_req_in) return 5'h08;
    if (b || !maskable_ack_enable_in) return 5'h00;
    for (i = 15; i >= 0; i--) begin
      if (req_pending_in[i%8] && priority_select_flag_in[i%8] == (i > 7) &&
          (!priority_select_flag_in[i%8] || in_service_priority_in)) mack = {2'b10, 3'(i%8)};
    end
  endfunction
  task automatic bnd(input int h, input int b, input int t);
    logic [4:0] e;
    e = mack(h, b, t);
    instr_class_in = {h[0], b[0]};
    intr_reg_touch_in = t[0];
    instr_done_in = 1'b1;
    cyc;
    instr_done_in = 1'b0;
    intr_reg_touch_in = 1'b0;
    chk({3'h0, ack_out}, {3'h0, e});
    cyc;
  endtask
  // Bits 3 to 6 of request and mask are never stored, whatever software writes
  task automatic wreg(input int s, input int b, input int i, input logic [7:0] d);
    reg_wr_in = {1'b1, b[0], s[1:0], i[2:0], d};
    if (b) m[s][i] = d[0];
    else m[s] = d;
    m[0] &= 8'h87;
    m[1] = (m[1] & 8'h87) | 8'h78;
    cyc;
    reg_wr_in = '0;
    cyc;
  endtask
  task automatic rdchk(input int s);
    rd_sel_in = s[1:0];
    cyc;
    chk(rd_data_out, m[s]);
  endtask
  task automatic ev(input logic t, input logic [7:0] k);
    logic f;
    f = |(kp & ~k);
    kp = k;
    tick = t;
    key_cmd = k;
    cyc;
    tick = 1'b0;
    cyc;
    m[0] |= {6'h0, f, t};
    chk({7'h0, standby_release_out}, {7'h0, (t & ~m[1][0]) | (f & ~m[1][1] & m[2][0])});
    chk({6'h0, key_test_flag_out, watch_test_flag_out}, m[0] & 8'h03);
  endtask
  initial begin
    {instr_done_in, maskable_ack_enable_in, in_service_priority_in, nmi_req_in} = '0;
    {intr_reg_touch_in, tick, req_pending_in, priority_select_flag_in, rd_sel_in} = '0;
    instr_class_in = '0;
    reg_wr_in = '0;
    key_cmd = 8'hff;
    kp = 8'hff;
    seed = 32'd24630;
    m = '{8'h00, 8'hff, 8'h02, 8'h00};
    rst_n_in = 1'b0;
    repeat (12) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    for (int s = 0; s < 4; s++) rdchk(s);
    // Software keeps bits 3 to 6 at their fixed values
    wreg(0, 0, 0, 8'h87);
    rdchk(0);
    wreg(0, 0, 0, 8'h00);
    wreg(1, 0, 0, 8'h78);
    rdchk(1);
    wreg(1, 1, 1, 8'h01);
    wreg(2, 1, 0, 8'h01);
    rdchk(1);
    // Low priority on every source must not change how the flags set
    priority_select_flag_in = 8'hff;
    ev(1'b1, 8'hff);
    ev(1'b0, 8'hfe);
    wreg(1, 1, 1, 8'h00);
    ev(1'b0, 8'hff);
    ev(1'b0, 8'h7f);
    wreg(2, 0, 0, 8'h02);
    ev(1'b0, 8'hff);
    ev(1'b0, 8'hbf);
    wreg(1, 1, 0, 8'h01);
    ev(1'b1, 8'hff);
    repeat (20) cyc;
    chk({7'h0, key_test_flag_out}, 8'h01);
    tick = 1'b1;
    cyc;
    tick = 1'b0;
    wreg(0, 0, 0, 8'h00);
    m[0][0] = 1'b1;
    rdchk(0);
    maskable_ack_enable_in = 1'b1;
    in_service_priority_in = 1'b1;
    req_pending_in = 8'h04;
    bnd(0, 0, 1);
    bnd(0, 0, 0);
    bnd(1, 0, 0);
    bnd(0, 0, 0);
    repeat (200) begin
      r = xs();
      {maskable_ack_enable_in, in_service_priority_in} = r[1:0];
      nmi_req_in = r[2] & r[3];
      req_pending_in = r[15:8];
      priority_select_flag_in = r[23:16];
      bnd(r[4] & r[5], r[6] & r[7], 0);
    end
    results;
  end
endmodule
`default_nettype wire
